// ### rtl/acdr_map.vh
// constants for the asynchronous receive clock and data recovery block
`ifndef ACDR_MAP_VH
`define ACDR_MAP_VH

// ****************************************
// samples per bit and voting positions
// ****************************************
`define ACDR_SPB_NORMAL 5'h10
`define ACDR_SPB_DOUBLE 5'h08
`define ACDR_VOTE_FIRST_NORMAL 5'h08
`define ACDR_VOTE_MID_NORMAL 5'h09
`define ACDR_VOTE_LAST_NORMAL 5'h0A
`define ACDR_VOTE_FIRST_DOUBLE 5'h04
`define ACDR_VOTE_MID_DOUBLE 5'h05
`define ACDR_VOTE_LAST_DOUBLE 5'h06
`define ACDR_CNT_W 5

// ****************************************
// frame length limits (data plus parity)
// ****************************************
`define ACDR_MIN_BITS 4'h5
`define ACDR_MAX_BITS 4'hA
`define ACDR_WORD_W 10

// ****************************************
// reset value and divider width
// ****************************************
`define ACDR_LINE_IDLE 1'b1
`define ACDR_DIV_W 12

`endif

// ### rtl/acdr_sync.v
// two-flop synchroniser for the receive line
`timescale 1ns/1ps
module acdr_sync (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // line
  input wire i_d,
  output wire o_q
);
  `include "acdr_map.vh"

  reg meta_reg;
  reg sync_reg;

  // idle level at reset so no false start edge appears on release
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_reg <= `ACDR_LINE_IDLE;
      sync_reg <= `ACDR_LINE_IDLE;
    end else begin
      meta_reg <= i_d;
      sync_reg <= meta_reg;
    end
  end

  assign o_q = sync_reg;
endmodule

// ### rtl/acdr_tick.v
// sample-rate enable divider: one pulse every divisor plus one clocks
`timescale 1ns/1ps
module acdr_tick #(
  parameter DIV_W = 12
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // control
  input wire i_run,
  input wire [DIV_W-1:0] i_div,
  // enable
  output wire o_tick
);
  reg [DIV_W-1:0] cnt_reg;
  reg tick_reg;

  // held in reload while stopped so the first sample phase is fresh
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_reg <= {DIV_W{1'b0}};
      tick_reg <= 1'b0;
    end else if (!i_run) begin
      cnt_reg <= i_div;
      tick_reg <= 1'b0;
    end else if (cnt_reg == {DIV_W{1'b0}}) begin
      cnt_reg <= i_div;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - {{(DIV_W-1){1'b0}}, 1'b1};
      tick_reg <= 1'b0;
    end
  end

  assign o_tick = tick_reg;
endmodule

// ### rtl/acdr_rx.v
// asynchronous receive clock and data recovery
// Function
// RULE_01: sixteen samples per bit, eight in double
// RULE_02: high-to-low sample starts detection, sample one
// RULE_03: start judged on samples 8-10 or 4-6
// RULE_04: majority high start is noise, resume search
// RULE_05: valid start resynchronises timing every frame
// RULE_06: per-bit sample state of sixteen or eight
// RULE_07: bit level is majority of three samples
// RULE_08: voting samples 8,9,10 or 4,5,6
// RULE_09: recover through first stop, ignore others
// RULE_10: zero first stop sets frame error
// RULE_11: normal speed: next start right after voting
// RULE_12: five to ten data-plus-parity bits supported
// RULE_13: accept roughly 95.36 to 104.58 percent rate
// RULE_14: receiver baud error within 2.0 or 1.5 percent
// RULE_15: double speed select one means eight samples
// RULE_16: transmitter keeps half the total rate error
// RULE_17: frame error travels with its frame word
// RULE_18: receiver disable aborts frame, flushes output
// RULE_19: line synchronised, idle samples treated high
// RULE_20: double speed: one extra sample before search
`timescale 1ns/1ps
`include "acdr_map.vh"

module acdr_rx #(
  parameter DIV_W = `ACDR_DIV_W
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // serial line from the remote transmitter
  input wire i_rxd,
  // control
  input wire i_receiver_enable_bit,
  input wire i_double_speed_select,
  input wire [DIV_W-1:0] i_baud_divisor_value,
  input wire [3:0] i_char_bits,
  // received frame
  output wire [`ACDR_WORD_W-1:0] o_data,
  output wire o_frame_error_flag,
  output wire o_valid,
  // status
  output wire o_busy
);

  // ****************************************
  // states
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_GAP = 3'h4;

  // ****************************************
  // functions
  // ****************************************
  // two-of-three vote: one disturbed sample cannot flip the bit
  function maj3;
    input a;
    input b;
    input c;
    begin
      maj3 = (a & b) | (a & c) | (b & c); // [RULE_07]
    end
  endfunction

  // sample position decode, shared by the start check and every bit
  function [`ACDR_CNT_W-1:0] vote_pos;
    input ds;
    input [1:0] which;
    begin
      case (which)
        2'h0: vote_pos = ds ? `ACDR_VOTE_FIRST_DOUBLE : `ACDR_VOTE_FIRST_NORMAL; // [RULE_08]
        2'h1: vote_pos = ds ? `ACDR_VOTE_MID_DOUBLE : `ACDR_VOTE_MID_NORMAL;
        default: vote_pos = ds ? `ACDR_VOTE_LAST_DOUBLE : `ACDR_VOTE_LAST_NORMAL;
      endcase
    end
  endfunction

  // ****************************************
  // line synchroniser and sample enable
  // ****************************************
  wire line_s;
  wire tick;

  acdr_sync u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d(i_rxd),
    .o_q(line_s)
  ); // [RULE_19]

  // the sample tick runs free and is not realigned at a start edge; the
  // sample count restarts instead, so the edge is known only to within one
  // sample period, which the centred vote absorbs
  acdr_tick #(
    .DIV_W(DIV_W)
  ) u_tick (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_run(i_receiver_enable_bit),
    .i_div(i_baud_divisor_value),
    .o_tick(tick)
  );

  // ****************************************
  // state
  // ****************************************
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`ACDR_CNT_W-1:0] cnt_reg;
  reg [`ACDR_CNT_W-1:0] cnt_next;
  reg [3:0] bit_reg;
  reg [3:0] bit_next;
  reg [3:0] nbits_reg;
  reg [3:0] nbits_next;
  reg ds_reg;
  reg ds_next;
  reg prev_reg;
  reg v0_reg;
  reg v0_next;
  reg v1_reg;
  reg v1_next;
  reg [`ACDR_WORD_W-1:0] shift_reg;
  reg [`ACDR_WORD_W-1:0] shift_next;
  reg [`ACDR_WORD_W-1:0] data_reg;
  reg [`ACDR_WORD_W-1:0] data_next;
  reg fe_reg;
  reg fe_next;
  reg valid_reg;
  reg valid_next;
  reg busy_reg;

  // ****************************************
  // combinational helpers
  // ****************************************
  wire [`ACDR_CNT_W-1:0] spb;
  wire [`ACDR_CNT_W-1:0] cnt_inc;
  wire [3:0] nbits_clamped;
  wire vote;

  // samples per bit follow the mode latched for this frame
  assign spb = ds_reg ? `ACDR_SPB_DOUBLE : `ACDR_SPB_NORMAL; // [RULE_01] [RULE_06] [RULE_15]
  // sample number of the sample taken on this tick
  assign cnt_inc = (cnt_reg == spb) ? {{(`ACDR_CNT_W-1){1'b0}}, 1'b1} :
                   cnt_reg + {{(`ACDR_CNT_W-1){1'b0}}, 1'b1}; // [RULE_06]
  // out-of-range lengths are pinned to the nearest supported length
  assign nbits_clamped = (i_char_bits < `ACDR_MIN_BITS) ? `ACDR_MIN_BITS :
                         (i_char_bits > `ACDR_MAX_BITS) ? `ACDR_MAX_BITS : i_char_bits; // [RULE_12]
  assign vote = maj3(v0_reg, v1_reg, line_s); // [RULE_07]

  // ****************************************
  // next-state logic
  // ****************************************
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    nbits_next = nbits_reg;
    ds_next = ds_reg;
    v0_next = v0_reg;
    v1_next = v1_reg;
    shift_next = shift_reg;
    data_next = data_reg;
    fe_next = fe_reg;
    valid_next = 1'b0;
    if (tick) begin
      case (state_reg)
        ST_IDLE: begin
          // a frame begins only on high then low at consecutive samples
          if (prev_reg && !line_s) begin // [RULE_02]
            state_next = ST_START;
            cnt_next = {{(`ACDR_CNT_W-1){1'b0}}, 1'b1}; // [RULE_05]
            bit_next = 4'h0;
            nbits_next = nbits_clamped;
            // mode and length are frozen for the frame, so a change made
            // mid-frame takes effect only at the next start edge
            ds_next = i_double_speed_select; // [RULE_15]
            shift_next = {`ACDR_WORD_W{1'b0}};
          end
        end
        ST_START: begin
          cnt_next = cnt_inc;
          if (cnt_inc == vote_pos(ds_reg, 2'h0)) begin // [RULE_03]
            v0_next = line_s;
          end
          if (cnt_inc == vote_pos(ds_reg, 2'h1)) begin
            v1_next = line_s;
          end
          // a rejected start returns to the search; the edge detector then
          // needs a fresh high sample before it can fire again
          if (cnt_inc == vote_pos(ds_reg, 2'h2) && vote) begin
            state_next = ST_IDLE; // [RULE_04]
          end
          if (cnt_inc == spb) begin
            state_next = ST_DATA;
            bit_next = 4'h1;
          end
        end
        ST_DATA: begin
          cnt_next = cnt_inc;
          if (cnt_inc == vote_pos(ds_reg, 2'h0)) begin // [RULE_08]
            v0_next = line_s;
          end
          if (cnt_inc == vote_pos(ds_reg, 2'h1)) begin
            v1_next = line_s;
          end
          // centred three-sample vote is what gives the rate tolerance margin
          if (cnt_inc == vote_pos(ds_reg, 2'h2)) begin // [RULE_13] [RULE_14] [RULE_16]
            shift_next[bit_reg - 4'h1] = vote; // [RULE_09]
          end
          if (cnt_inc == spb) begin
            if (bit_reg == nbits_reg) begin
              state_next = ST_STOP;
            end else begin
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        ST_STOP: begin
          cnt_next = cnt_inc;
          if (cnt_inc == vote_pos(ds_reg, 2'h0)) begin
            v0_next = line_s;
          end
          if (cnt_inc == vote_pos(ds_reg, 2'h1)) begin
            v1_next = line_s;
          end
          // only the first stop bit is examined; later ones are ignored
          if (cnt_inc == vote_pos(ds_reg, 2'h2)) begin // [RULE_09]
            data_next = shift_reg;
            // a zero stop leaves prev_reg low, so no false start follows it
            fe_next = ~vote; // [RULE_10] [RULE_17]
            valid_next = 1'b1;
            state_next = ds_reg ? ST_GAP : ST_IDLE; // [RULE_11] [RULE_20]
          end
        end
        ST_GAP: begin
          // one sample period of hold-off before edge search in double speed
          cnt_next = cnt_inc;
          state_next = ST_IDLE; // [RULE_20]
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // enable low is a synchronous clear of the whole receiver; the
  // synchroniser keeps running so the line history stays current
  always @(posedge i_clk) begin
    if (!i_nrst || !i_receiver_enable_bit) begin
      // disable acts at once: frame in progress and held result are dropped
      state_reg <= ST_IDLE; // [RULE_18]
      cnt_reg <= {`ACDR_CNT_W{1'b0}};
      bit_reg <= 4'h0;
      nbits_reg <= `ACDR_MIN_BITS;
      ds_reg <= 1'b0;
      prev_reg <= `ACDR_LINE_IDLE; // [RULE_19]
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
      shift_reg <= {`ACDR_WORD_W{1'b0}};
      data_reg <= {`ACDR_WORD_W{1'b0}}; // [RULE_18]
      fe_reg <= 1'b0;
      valid_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      nbits_reg <= nbits_next;
      ds_reg <= ds_next;
      if (tick) begin
        prev_reg <= line_s;
      end
      v0_reg <= v0_next;
      v1_reg <= v1_next;
      shift_reg <= shift_next;
      data_reg <= data_next;
      fe_reg <= fe_next;
      valid_reg <= valid_next;
      busy_reg <= (state_next != ST_IDLE);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // o_valid is a one-clock strobe; o_data and o_frame_error_flag hold
  // until the next frame completes or the receiver is disabled
  // o_busy stays high through the double speed hold-off sample, so a
  // user sees it fall only once a new start can be taken
  assign o_data = data_reg;
  assign o_frame_error_flag = fe_reg;
  assign o_valid = valid_reg;
  assign o_busy = busy_reg;
endmodule

// ### test/acdr_rx_props.sv
// assertions on the ports of the receive recovery block
`timescale 1ns/1ps
module acdr_rx_props #(
  parameter DIV_W = 12
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // line and control
  input wire i_rxd,
  input wire i_receiver_enable_bit,
  input wire i_double_speed_select,
  input wire [DIV_W-1:0] i_baud_divisor_value,
  input wire [3:0] i_char_bits,
  // frame result
  input wire [9:0] o_data,
  input wire o_frame_error_flag,
  input wire o_valid,
  input wire o_busy
);
  // ****************************************
  // properties
  // ****************************************
  // lengths outside five to ten are clamped by the block
  wire [3:0] nb = (i_char_bits < 4'h5) ? 4'h5 : ((i_char_bits > 4'hA) ? 4'hA : i_char_bits);
  // mode of the frame in flight, taken while idle just as the block latches it
  reg ds_seen;
  always @(posedge i_clk) begin
    if (!o_busy) begin
      ds_seen <= i_double_speed_select;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_valid_one_cycle: assert property (o_valid |=> !o_valid)
    else $error("valid held too long");
  a_valid_ends_busy: assert property (o_valid |-> o_busy == ds_seen)
    else $error("busy wrong with valid");
  a_busy_bounded: assert property ($rose(o_busy) |-> ##[1:1000] !o_busy)
    else $error("frame never ends");
  a_start_hold: assert property ($rose(o_busy) |-> o_busy [*8])
    else $error("start dropped before its check");
  a_start_low: assert property ($rose(o_busy) |-> !$past(i_rxd, 3))
    else $error("busy without low line");
  a_valid_after_busy: assert property (o_valid |-> $past(o_busy))
    else $error("valid without a frame");
  a_upper_zero: assert property (o_valid |-> (o_data >> nb) == 10'h000)
    else $error("bits above length set");
  a_result_stable: assert property (disable iff (!i_nrst || !i_receiver_enable_bit)
    !o_valid |-> $stable(o_data) && $stable(o_frame_error_flag)) else $error("result moved");
  a_disable_clears: assert property (!i_receiver_enable_bit |=>
    !o_busy && !o_valid && o_data == 10'h000 && !o_frame_error_flag) else $error("disable left state");
  cover property (o_valid && o_frame_error_flag);
  cover property (o_valid && i_double_speed_select);
  cover property ($fell(o_busy) && !o_valid);
endmodule

bind acdr_rx acdr_rx_props #(.DIV_W(DIV_W)) u_props (.i_clk(i_clk), .i_nrst(i_nrst), .i_rxd(i_rxd),
  .i_receiver_enable_bit(i_receiver_enable_bit), .i_double_speed_select(i_double_speed_select),
  .i_baud_divisor_value(i_baud_divisor_value), .i_char_bits(i_char_bits), .o_data(o_data),
  .o_frame_error_flag(o_frame_error_flag), .o_valid(o_valid), .o_busy(o_busy));

// ### test/acdr_tx_model.sv
// remote transmitter model driving the receive line
`timescale 1ns/1ps
module acdr_tx_model (
  input wire i_clk,
  output reg o_line
);
  initial o_line = 1'b1;
  // exact timing for the given spb and cps; t_rate sets them off the receiver rate to spend part of the error budget
  task automatic send(input [9:0] w, input integer nb, spb, cps, stop_len, gbit, input st);
    integer b;
    integer s;
    reg v;
    begin
      for (b = 0; b <= nb + 1; b = b + 1) begin
        v = (b == 0) ? 1'b0 : ((b <= nb) ? w[b-1] : st);
        for (s = 1; s <= ((b > nb) ? stop_len : spb); s = s + 1) begin
          repeat (cps) @(posedge i_clk) o_line <= v ^ (b == gbit && s == 9);
        end
      end
      // a zero stop must not look like a held start afterwards
      if (!st) repeat (cps * spb) @(posedge i_clk) o_line <= 1'b1;
    end
  endtask
  task automatic pulse_low(input integer n);
    begin
      repeat (n) @(posedge i_clk) o_line <= 1'b0;
      @(posedge i_clk) o_line <= 1'b1;
    end
  endtask
endmodule

// ### test/tb_top.sv
// self-checking bench for the receive recovery block
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg en = 1'b1;
  reg ds = 1'b0;
  reg [3:0] nbits = 4'h8;
  reg got;
  wire rxd;
  wire [9:0] data;
  wire fe;
  wire valid;
  wire busy;
  integer n_errors = 0;
  integer cmp_count = 0;
  always #20 clk = ~clk;
  acdr_tx_model tx (.i_clk(clk), .o_line(rxd));
  acdr_rx #(.DIV_W(12)) dut (.i_clk(clk), .i_nrst(nrst), .i_rxd(rxd), .i_receiver_enable_bit(en),
    .i_double_speed_select(ds), .i_baud_divisor_value(12'h001), .i_char_bits(nbits), .o_data(data),
    .o_frame_error_flag(fe), .o_valid(valid), .o_busy(busy));
  // ****************************************
  // helpers
  // ****************************************
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task check(input [11:0] seen, input [11:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // divisor 1 gives two clocks per sample, so a frame is under 400 clocks
  task wait_valid(input want);
    integer k;
    begin
      got = 1'b0;
      for (k = 0; k < 1200 && !got; k = k + 1) begin
        @(posedge clk);
        #1 got = (valid === 1'b1);
      end
      if (want && !got) begin
        check(got, 1'b1);
        end_sim;
      end
    end
  endtask
  task t_frame(input [9:0] w, input [3:0] n, input d, input st, input integer gbit);
    begin
      @(posedge clk);
      ds <= d;
      nbits <= n;
      fork
        tx.send(w, n, d ? 8 : 16, 2, d ? 8 : 16, gbit, st);
        begin
          wait_valid(1'b1);
          check({fe, 1'b0, data}, {~st, 1'b0, w});
        end
      join
      $display("frame %h done", w);
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_noise;
    begin
      tx.pulse_low(6);
      wait_valid(1'b0);
      check(got, 1'b0);
      $display("noise test done");
    end
  endtask
  task t_back;
    begin
      @(posedge clk);
      ds <= 1'b0;
      nbits <= 4'h8;
      fork
        begin
          tx.send(10'h03C, 8, 16, 2, 10, -1, 1'b1);
          tx.send(10'h0C3, 8, 16, 2, 16, -1, 1'b1);
        end
        begin
          wait_valid(1'b1);
          check(data, 10'h03C);
          wait_valid(1'b1);
          check(data, 10'h0C3);
        end
      join
      $display("back to back done");
    end
  endtask
  task t_disable;
    begin
      fork
        tx.send(10'h155, 8, 16, 2, 16, -1, 1'b1);
        begin
          repeat (100) @(posedge clk);
          en <= 1'b0;
          repeat (2) @(posedge clk);
          #1 check({busy, valid, data}, 12'h000);
        end
      join
      @(posedge clk);
      en <= 1'b1;
      $display("disable test done");
    end
  endtask
  // one sample per clock at len clocks a bit against 32 in the receiver
  task t_rate(input integer len);
    begin
      @(posedge clk);
      ds <= 1'b0;
      nbits <= 4'h8;
      fork
        tx.send(10'h0D2, 8, len, 1, len, -1, 1'b1);
        begin
          wait_valid(1'b1);
          check({fe, 1'b0, data}, 12'h0D2);
        end
      join
      $display("rate %0d done", len);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_frame(10'h0A5, 4'h8, 1'b0, 1'b1, -1);
    t_frame(10'h05A, 4'h8, 1'b1, 1'b1, -1);
    t_frame(10'h015, 4'h5, 1'b0, 1'b1, -1);
    t_frame(10'h2C3, 4'hA, 1'b1, 1'b1, -1);
    t_frame(10'h0F6, 4'h8, 1'b0, 1'b1, 2);
    t_frame(10'h033, 4'h8, 1'b0, 1'b0, -1);
    t_noise;
    t_back;
    t_disable;
    t_frame(10'h081, 4'h8, 1'b0, 1'b1, -1);
    t_rate(31);
    t_rate(33);
    end_sim;
  end
endmodule
